// File: hdl/byte_shifter.sv
// msb-first instruction shifter with a saturating bit counter
`timescale 1ns/1ps
`include "dpd_cfg.svh"
module byte_shifter (
	input wire logic clk_i,        // system clock
	input wire logic rst_i,        // synchronous reset, active high
	input wire logic clear_i,      // chip select high: clear counter
	input wire logic shift_i,      // serial clock rising while selected
	input wire logic bit_i,        // serial input bit
	output logic [7:0] data_o,     // last eight bits shifted in
	output logic [3:0] count_o     // bits seen, stuck at nine once past eight
);
	typedef struct packed {
		logic [7:0] data;
		logic [3:0] count;
	} shift_type;

	shift_type q;
	shift_type d;

	always_comb begin
		d = q;
		if (clear_i) begin
			d.count = 4'h0;
		end else if (shift_i) begin
			d.data = {q.data[6:0], bit_i};
			if (q.count <= `DPD_BITS_PER_OP) begin
				d.count = q.count + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign data_o = q.data;
	assign count_o = q.count;
endmodule

// File: hdl/dpd_cfg.svh
// constants for the deep power-down control link and both of its ends
`ifndef DPD_CFG_SVH
`define DPD_CFG_SVH

`define DPD_OP_ENTER 8'hb9
`define DPD_OP_RELEASE 8'hab
`define DPD_OP_RST_ENABLE 8'h66
`define DPD_OP_RST_DEVICE 8'h99
`define DPD_OP_RST_FF 8'hff

`define DPD_BITS_PER_OP 4'h8
`define DPD_HW_PULSES 3'h4

`define DPD_CLK_PERIOD_NS 5
`define DPD_SYNC_CYCLES 3
`define DPD_ENTRY_DELAY_NS 3000
`define DPD_ENTRY_CYCLES (`DPD_ENTRY_DELAY_NS / `DPD_CLK_PERIOD_NS)
`define DPD_RELEASE_TIME_NS 1500000
`define DPD_RELEASE_CYCLES (`DPD_RELEASE_TIME_NS / `DPD_CLK_PERIOD_NS)
`define DPD_TIMER_W 19

`define DPD_LINK_HALF_CYCLES 5'h10
`define DPD_TICK_W 5

`endif

// File: hdl/dpd_device.sv
// device end: deep power-down entry, release and reset handling on the serial link
`timescale 1ns/1ps
`include "dpd_cfg.svh"
module dpd_device #(
	parameter int RELEASE_CYCLES = `DPD_RELEASE_CYCLES
) (
	input wire logic CLOCK_I,          // system clock, 200 MHz
	input wire logic RST_I,            // synchronous reset, active high
	dpd_link_if.device LINK,           // serial link from the host
	output logic CMD_VALID_O,          // pulse: instruction taken in normal operation
	output logic [7:0] CMD_O,          // instruction byte, held until the next one
	output logic SW_RESET_O,           // pulse: reset instruction woke the device
	output logic HW_RESET_O,           // pulse: reset protocol seen on the pins
	output logic POWER_DOWN_O,         // level: in deep power-down
	output logic READY_O               // level: normal operation, instructions taken
);
	// a pin edge reaches the mode register three cycles late (two sync flops, one edge
	// flop), so the timers stop that much earlier and the limits hold from the pin itself
	localparam int ENTRY_LAST = `DPD_ENTRY_CYCLES - `DPD_SYNC_CYCLES - 1;
	localparam int RELEASE_LAST = RELEASE_CYCLES - `DPD_SYNC_CYCLES - 1;
	// the reset protocol fires on the rising select edge that ends the last pulse
	localparam logic [2:0] HW_LAST = `DPD_HW_PULSES - 3'h1;

	typedef struct packed {
		logic [2:0] cs_s;
		logic [2:0] sclk_s;
		logic [1:0] mosi_s;
		dpd_pkg::dev_mode_type mode;
		logic [`DPD_TIMER_W-1:0] timer;
		logic rst_armed;
		logic [2:0] hw_cnt;
		logic hw_ok;
		logic cmd_valid;
		logic [7:0] cmd;
		logic sw_rst;
		logic hw_rst;
	} dev_type;

	dev_type q;
	dev_type d;

	// edge strobes taken from the synchronised pins
	logic cs_rise;
	logic cs_fall;
	logic sclk_rise;
	logic selected;
	logic full_byte;
	logic [7:0] op;
	logic [3:0] bit_count;
	logic hw_step;
	logic hw_done;

	// stage 0 of each synchroniser feeds stage 1 only; edges use stages 1 and 2
	assign cs_rise = q.cs_s[1] & ~q.cs_s[2];
	assign cs_fall = ~q.cs_s[1] & q.cs_s[2];
	assign sclk_rise = q.sclk_s[1] & ~q.sclk_s[2];
	assign selected = ~q.cs_s[1];

	// the shifter clears its count whenever select is high
	byte_shifter shifter (
		.clk_i(CLOCK_I),
		.rst_i(RST_I),
		.clear_i(q.cs_s[1]),
		.shift_i(sclk_rise & selected),
		.bit_i(q.mosi_s[1]),
		.data_o(op),
		.count_o(bit_count)
	);

	// a byte counts only if chip select rose with exactly eight bits in
	assign full_byte = cs_rise && (bit_count == `DPD_BITS_PER_OP);

	// one good reset pulse: no clock edge inside it and the expected input at its fall
	assign hw_step = cs_rise && (bit_count == 4'h0) && q.hw_ok;
	assign hw_done = hw_step && (q.hw_cnt == HW_LAST);

	always_comb begin
		d = q;
		d.cs_s = {q.cs_s[1:0], LINK.cs_n};
		d.sclk_s = {q.sclk_s[1:0], LINK.sclk};
		d.mosi_s = {q.mosi_s[0], LINK.mosi};
		// result pulses last one cycle
		d.cmd_valid = 1'b0;
		d.sw_rst = 1'b0;
		d.hw_rst = 1'b0;

		case (q.mode)
			dpd_pkg::DEV_NORMAL: begin
				if (full_byte) begin
					if (op == `DPD_OP_ENTER) begin
						d.mode = dpd_pkg::DEV_ENTERING;
						d.timer = '0;
					end else begin
						// anything else, status read included, goes to the user side;
						// resets in normal operation are plain commands for the user side
						d.cmd_valid = 1'b1;
						d.cmd = op;
					end
				end
				// a cut-short entry frame falls through here and changes nothing
				d.rst_armed = 1'b0;
			end

			dpd_pkg::DEV_ENTERING: begin
				// frames during the entry delay are dropped, like in power-down;
				// the timer starts on the first cycle that sees select high
				if (q.timer == `DPD_TIMER_W'(ENTRY_LAST)) begin
					d.mode = dpd_pkg::DEV_DOWN;
					d.timer = '0;
				end else begin
					d.timer = q.timer + `DPD_TIMER_W'(1);
				end
			end

			dpd_pkg::DEV_DOWN: begin
				if (full_byte) begin
					d.rst_armed = 1'b0;
					if (op == `DPD_OP_RELEASE) begin
						d.mode = dpd_pkg::DEV_RECOVER;
						d.timer = '0;
					end else if (op == `DPD_OP_RST_FF) begin
						d.mode = dpd_pkg::DEV_NORMAL;
						d.sw_rst = 1'b1;
					end else if (op == `DPD_OP_RST_ENABLE) begin
						// arms only; the very next full frame must be the 99
						d.rst_armed = 1'b1;
					end else if (op == `DPD_OP_RST_DEVICE && q.rst_armed) begin
						d.mode = dpd_pkg::DEV_NORMAL;
						d.sw_rst = 1'b1;
					end
				end
				// no cmd_valid here: every other byte, status read too, is lost
				d.cmd_valid = 1'b0;
			end

			dpd_pkg::DEV_RECOVER: begin
				// the host keeps chip select high meanwhile; stray frames are dropped
				if (q.timer == `DPD_TIMER_W'(RELEASE_LAST)) begin
					d.mode = dpd_pkg::DEV_NORMAL;
					d.timer = '0;
				end else begin
					d.timer = q.timer + `DPD_TIMER_W'(1);
				end
			end

			default: begin
				d.mode = dpd_pkg::DEV_NORMAL;
			end
		endcase

		// reset protocol: four select pulses with no clock, input 0,1,0,1 at each fall;
		// it works in every mode and overrides whatever the case above decided
		if (cs_fall) begin
			d.hw_ok = (q.mosi_s[1] == q.hw_cnt[0]);
		end
		if (cs_rise) begin
			if (hw_step) begin
				if (hw_done) begin
					d.hw_cnt = 3'h0;
					d.hw_rst = 1'b1;
					d.mode = dpd_pkg::DEV_NORMAL;
					d.timer = '0;
					d.rst_armed = 1'b0;
					d.cmd_valid = 1'b0;
					d.sw_rst = 1'b0;
				end else begin
					d.hw_cnt = q.hw_cnt + 3'h1;
				end
			end else begin
				d.hw_cnt = 3'h0;
			end
		end
	end

	// select synchroniser presets high so release of reset shows no false select edge
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			q <= '0;
			q.cs_s <= 3'h7;
			q.mode <= dpd_pkg::DEV_NORMAL;
		end else begin
			q <= d;
		end
	end

	// every output is a register or a plain decode of the registered mode
	assign CMD_VALID_O = q.cmd_valid;
	assign CMD_O = q.cmd;
	assign SW_RESET_O = q.sw_rst;
	assign HW_RESET_O = q.hw_rst;
	assign POWER_DOWN_O = (q.mode == dpd_pkg::DEV_DOWN);
	assign READY_O = (q.mode == dpd_pkg::DEV_NORMAL);
endmodule

// File: hdl/dpd_host.sv
// host end: shifts single instruction bytes or the reset protocol onto the link
`timescale 1ns/1ps
`include "dpd_cfg.svh"
module dpd_host #(
	parameter int RELEASE_CYCLES = `DPD_RELEASE_CYCLES
) (
	input wire logic CLOCK_I,              // system clock, 200 MHz
	input wire logic RST_I,                // synchronous reset, active high
	dpd_link_if.host LINK,                 // serial link to the device
	input wire logic REQ_I,                // request, taken while not busy
	input wire dpd_pkg::host_op_type OP_I, // byte frame or reset protocol
	input wire logic [7:0] BYTE_I,         // instruction byte for a byte frame
	output logic BUSY_O,                   // level: request in progress
	output logic DONE_O                    // pulse: request finished
);
	localparam int RELEASE_LAST = RELEASE_CYCLES - 1;

	typedef struct packed {
		dpd_pkg::host_state_type state;
		logic cs_n;
		logic sclk;
		logic mosi;
		logic [`DPD_TICK_W-1:0] tick_cnt;
		logic [2:0] bit_cnt;
		logic [7:0] sh;
		logic [2:0] hw_cnt;
		logic [`DPD_TIMER_W-1:0] wait_cnt;
		logic release_op;
		logic done;
	} host_type;

	host_type q;
	host_type d;
	logic tick;

	// the link clock is this clock divided; one tick per half period
	assign tick = (q.tick_cnt == `DPD_LINK_HALF_CYCLES - `DPD_TICK_W'(1));

	always_comb begin
		d = q;
		d.done = 1'b0;
		d.tick_cnt = tick ? '0 : q.tick_cnt + `DPD_TICK_W'(1);
		case (q.state)
			dpd_pkg::H_IDLE: begin
				d.tick_cnt = '0;
				if (REQ_I) begin
					d.bit_cnt = 3'h0;
					d.hw_cnt = 3'h0;
					d.sh = BYTE_I;
					d.release_op = (OP_I == dpd_pkg::HOP_BYTE) && (BYTE_I == `DPD_OP_RELEASE);
					if (OP_I == dpd_pkg::HOP_BYTE) begin
						d.state = dpd_pkg::H_SEL;
						d.cs_n = 1'b0;
						d.mosi = BYTE_I[7];
					end else begin
						d.state = dpd_pkg::H_HWSET;
						d.mosi = 1'b0;
					end
				end
			end
			dpd_pkg::H_SEL: begin
				if (tick) begin
					d.sclk = 1'b1;
					d.state = dpd_pkg::H_HIGH;
				end
			end
			dpd_pkg::H_HIGH: begin
				if (tick) begin
					d.sclk = 1'b0;
					if (q.bit_cnt == 3'h7) begin
						d.state = dpd_pkg::H_END;
					end else begin
						d.bit_cnt = q.bit_cnt + 3'h1;
						d.sh = {q.sh[6:0], 1'b0};
						d.mosi = q.sh[6];
						d.state = dpd_pkg::H_LOW;
					end
				end
			end
			dpd_pkg::H_LOW: begin
				if (tick) begin
					d.sclk = 1'b1;
					d.state = dpd_pkg::H_HIGH;
				end
			end
			dpd_pkg::H_END: begin
				// deselect right after the eighth bit, before any ninth clock
				if (tick) begin
					d.cs_n = 1'b1;
					d.state = dpd_pkg::H_GAP;
				end
			end
			dpd_pkg::H_GAP: begin
				if (tick) begin
					if (q.release_op) begin
						d.wait_cnt = '0;
						d.state = dpd_pkg::H_RECOV;
					end else begin
						d.done = 1'b1;
						d.state = dpd_pkg::H_IDLE;
					end
				end
			end
			dpd_pkg::H_RECOV: begin
				// select stays high for the whole recovery time
				if (q.wait_cnt == `DPD_TIMER_W'(RELEASE_LAST)) begin
					d.done = 1'b1;
					d.state = dpd_pkg::H_IDLE;
				end else begin
					d.wait_cnt = q.wait_cnt + `DPD_TIMER_W'(1);
				end
			end
			dpd_pkg::H_HWSET: begin
				if (tick) begin
					d.cs_n = 1'b0;
					d.state = dpd_pkg::H_HWLOW;
				end
			end
			dpd_pkg::H_HWLOW: begin
				if (tick) begin
					d.cs_n = 1'b1;
					if (q.hw_cnt == `DPD_HW_PULSES - 3'h1) begin
						d.state = dpd_pkg::H_GAP;
					end else begin
						d.hw_cnt = q.hw_cnt + 3'h1;
						d.mosi = ~q.hw_cnt[0];
						d.state = dpd_pkg::H_HWSET;
					end
				end
			end
			default: begin
				d.state = dpd_pkg::H_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			q <= '0;
			q.state <= dpd_pkg::H_IDLE;
			q.cs_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign LINK.cs_n = q.cs_n;
	assign LINK.sclk = q.sclk;
	assign LINK.mosi = q.mosi;
	assign BUSY_O = (q.state != dpd_pkg::H_IDLE);
	assign DONE_O = q.done;
endmodule

// File: hdl/dpd_link_if.sv
// serial link between host and device: chip select, serial clock, serial input
`timescale 1ns/1ps
interface dpd_link_if;
	logic cs_n;
	logic sclk;
	logic mosi;

	modport host (
		output cs_n,
		output sclk,
		output mosi
	);

	modport device (
		input cs_n,
		input sclk,
		input mosi
	);
endinterface

// File: hdl/dpd_pkg.sv
// types shared by the deep power-down device end and host end
package dpd_pkg;
	typedef enum logic [1:0] {
		DEV_NORMAL,
		DEV_ENTERING,
		DEV_DOWN,
		DEV_RECOVER
	} dev_mode_type;

	typedef enum logic [3:0] {
		H_IDLE,
		H_SEL,
		H_HIGH,
		H_LOW,
		H_END,
		H_GAP,
		H_RECOV,
		H_HWSET,
		H_HWLOW
	} host_state_type;

	typedef enum logic {
		HOP_BYTE,
		HOP_HW_RESET
	} host_op_type;
endpackage

// File: tb/dpd_checker.sv
// assertions on the host-to-device link and the device mode outputs
`timescale 1ns/1ps
module dpd_checker #(
	parameter int RELEASE_CYCLES = 300000
) (
	input wire logic CLOCK_I,      // system clock
	input wire logic RST_I,        // sync reset
	input wire logic cs_n,         // chip select
	input wire logic sclk,         // link clock
	input wire logic mosi,         // serial data
	input wire logic CMD_VALID_O,  // command pulse
	input wire logic SW_RESET_O,   // software reset pulse
	input wire logic HW_RESET_O,   // pin reset pulse
	input wire logic POWER_DOWN_O, // powered down
	input wire logic READY_O       // normal operation
);
	logic [19:0] since_q;
	logic cs_q;

	// cycles since chip select last rose; saturates so idle time never wraps
	always_ff @(posedge CLOCK_I) begin
		cs_q <= cs_n;
		if (RST_I)
			since_q <= 20'hfffff;
		else if (cs_n && !cs_q)
			since_q <= 20'h0;
		else if (since_q != 20'hfffff)
			since_q <= since_q + 20'h1;
	end

	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (RST_I);

	sequence s_wake;
		$fell(POWER_DOWN_O) && !READY_O;
	endsequence
	sequence s_idle_down;
		POWER_DOWN_O && cs_n && since_q > 20'h10;
	endsequence

	property p_start;
		$fell(RST_I) |-> READY_O && !POWER_DOWN_O;
	endproperty
	property p_sclk_idle;
		cs_n |-> !sclk;
	endproperty
	property p_cmd;
		CMD_VALID_O |-> READY_O && since_q >= 20'h2 && since_q <= 20'h8;
	endproperty
	property p_entry;
		$rose(POWER_DOWN_O) |-> since_q <= 20'h257;
	endproperty
	property p_stay;
		s_idle_down |=> POWER_DOWN_O;
	endproperty
	property p_excl;
		!(POWER_DOWN_O && READY_O);
	endproperty
	property p_recover;
		s_wake |=> !READY_O [*8];
	endproperty
	property p_recov_time;
		$rose(READY_O) |-> since_q <= RELEASE_CYCLES - 1;
	endproperty
	property p_sw;
		SW_RESET_O |-> ##[0:1] READY_O;
	endproperty
	property p_hw;
		HW_RESET_O |-> ##[0:1] READY_O;
	endproperty
	property p_leave;
		$fell(POWER_DOWN_O) |-> since_q >= 20'h2 && since_q <= 20'h4;
	endproperty
	property p_hold_cs;
		$fell(cs_n) |-> READY_O || POWER_DOWN_O;
	endproperty

	a_start: assert property (p_start) else $error("not ready after reset");
	a_sclk_idle: assert property (p_sclk_idle) else $error("clock moved while idle");
	a_cmd: assert property (p_cmd) else $error("command out of place");
	a_entry: assert property (p_entry) else $error("entry too slow");
	a_stay: assert property (p_stay) else $error("left power-down alone");
	a_excl: assert property (p_excl) else $error("ready while down");
	a_recover: assert property (p_recover) else $error("no recovery wait");
	a_recov_time: assert property (p_recov_time) else $error("recovery too slow");
	a_sw: assert property (p_sw) else $error("software reset kept down");
	a_hw: assert property (p_hw) else $error("pin reset kept down");
	a_leave: assert property (p_leave) else $error("left power-down without a frame");
	a_hold_cs: assert property (p_hold_cs) else $error("select fell during recovery");
endmodule

// File: tb/tb_top.sv
// self-checking bench: host and device joined, plus a bench-driven link
`timescale 1ns/1ps
module tb_top;
	localparam int REL = 200;
	logic clk_i, rst_i, req_i, busy_o, done_o, cv_o, sw_o, hw_o, pd_o, rdy_o, pd2_o, rdy2_o;
	dpd_pkg::host_op_type op_i;
	logic [7:0] byte_i, r, cmd_o;
	logic [10:0] q[$];
	int failures, compares, seed, i;
	dpd_link_if lk();
	dpd_link_if bk();

	dpd_host #(.RELEASE_CYCLES(REL)) u_dpd_host (.CLOCK_I(clk_i), .RST_I(rst_i),
		.LINK(lk.host), .REQ_I(req_i), .OP_I(op_i), .BYTE_I(byte_i), .BUSY_O(busy_o),
		.DONE_O(done_o));
	dpd_device #(.RELEASE_CYCLES(REL)) u_dpd_device (.CLOCK_I(clk_i), .RST_I(rst_i),
		.LINK(lk.device), .CMD_VALID_O(cv_o), .CMD_O(cmd_o), .SW_RESET_O(sw_o),
		.HW_RESET_O(hw_o), .POWER_DOWN_O(pd_o), .READY_O(rdy_o));
	dpd_device #(.RELEASE_CYCLES(REL)) u_dpd_device_2 (.CLOCK_I(clk_i), .RST_I(rst_i),
		.LINK(bk.device), .CMD_VALID_O(), .CMD_O(), .SW_RESET_O(), .HW_RESET_O(),
		.POWER_DOWN_O(pd2_o), .READY_O(rdy2_o));
	dpd_checker #(.RELEASE_CYCLES(REL)) u_dpd_checker (.CLOCK_I(clk_i), .RST_I(rst_i),
		.cs_n(lk.cs_n), .sclk(lk.sclk), .mosi(lk.mosi), .CMD_VALID_O(cv_o),
		.SW_RESET_O(sw_o), .HW_RESET_O(hw_o), .POWER_DOWN_O(pd_o), .READY_O(rdy_o));

	task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic send(input dpd_pkg::host_op_type op, input logic [7:0] b);
		op_i = op;
		byte_i = b;
		req_i = 1'b1;
		cyc(1);
		req_i = 1'b0;
		chk(busy_o, 1'b1);
		for (i = 0; i < 1000 && done_o !== 1'b1; i++)
			cyc(1);
		if (i == 1000) begin
			failures++;
			end_of_test;
		end
		chk(busy_o, 1'b0);
	endtask
	task automatic wpd(input logic v);
		for (i = 0; i < 700 && pd_o !== v; i++)
			cyc(1);
		chk(pd_o, v);
	endtask
	// bench link: n clock rises, so frames can be cut short or run long
	task automatic bframe(input logic [7:0] d, input int n);
		bk.cs_n = 1'b0;
		for (int k = 0; k < n; k++) begin
			bk.mosi = d[7 - k % 8];
			cyc(16);
			bk.sclk = 1'b1;
			cyc(16);
			bk.sclk = 1'b0;
		end
		cyc(16);
		bk.cs_n = 1'b1;
		bk.mosi = ~bk.mosi;
		cyc(32);
	endtask

	// each result pulse takes the oldest note; none pending means it was unasked for
	always @(negedge clk_i) begin
		if (rst_i === 1'b0 && (cv_o | sw_o | hw_o) === 1'b1)
			chk({cv_o, sw_o, hw_o, cv_o ? cmd_o : 8'h0}, q.size() ? q.pop_front() : 11'h0);
	end

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	initial begin
		seed = 32'ha8de;
		failures = 0;
		compares = 0;
		rst_i = 1'b1;
		req_i = 1'b0;
		op_i = dpd_pkg::HOP_BYTE;
		byte_i = 8'h0;
		bk.cs_n = 1'b1;
		bk.sclk = 1'b0;
		bk.mosi = 1'b0;
		cyc(16);
		rst_i = 1'b0;
		cyc(4);
		chk({rdy_o, pd_o, rdy2_o, pd2_o}, 11'ha);
		$display("test reset done");
		for (int n = 0; n < 6; n++) begin
			r = n == 0 ? 8'h05 : n == 1 ? 8'hff : n == 2 ? 8'h66 : 8'($random(seed));
			if (r == 8'hb9 || r == 8'hab)
				r = 8'h5a;
			q.push_back({3'h4, r});
			send(dpd_pkg::HOP_BYTE, r);
		end
		$display("test normal traffic done");
		for (int k = 0; k < 4; k++) begin
			send(dpd_pkg::HOP_BYTE, 8'hb9);
			wpd(1'b1);
			send(dpd_pkg::HOP_BYTE, 8'h05);
			send(dpd_pkg::HOP_BYTE, 8'h10 | (8'($random(seed)) & 8'h0f));
			chk(pd_o, 1'b1);
			case (k)
			0: send(dpd_pkg::HOP_BYTE, 8'hab);
			1: begin
				q.push_back(11'h200);
				send(dpd_pkg::HOP_BYTE, 8'hff);
			end
			2: begin
				send(dpd_pkg::HOP_BYTE, 8'h66);
				q.push_back(11'h200);
				send(dpd_pkg::HOP_BYTE, 8'h99);
			end
			default: begin
				send(dpd_pkg::HOP_BYTE, 8'h66);
				send(dpd_pkg::HOP_BYTE, 8'h05);
				send(dpd_pkg::HOP_BYTE, 8'h99);
				chk(pd_o, 1'b1);
				q.push_back(11'h100);
				send(dpd_pkg::HOP_HW_RESET, 8'h0);
			end
			endcase
			chk({rdy_o, pd_o}, 11'h2);
		end
		$display("test power-down wake ways done");
		bframe(8'hb9, 7);
		cyc(640);
		chk({rdy2_o, pd2_o}, 11'h2);
		bframe(8'hb9, 9);
		cyc(640);
		chk({rdy2_o, pd2_o}, 11'h2);
		bframe(8'hb9, 8);
		cyc(640);
		chk({rdy2_o, pd2_o}, 11'h1);
		$display("test frame termination done");
		chk(11'(q.size()), 11'h0);
		end_of_test;
	end
endmodule
